// *** src/icmo_ctrl.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "icmo_params.svh"
module icmo_ctrl
   import icmo_pkg::*;
#(
   parameter int ADDR_BITS = 32,
   parameter int SET_BITS  = `ICMO_SET_BITS
) (
   // Clock and reset
   input  wire logic                  i_ref_clk,
   input  wire logic                  i_rst,
   // Issued instruction and register file read
   input  wire logic                  i_issue,
   input  wire logic [31:0]           i_instr,
   input  wire logic [ADDR_BITS-1:0]  i_base_value,
   input  wire logic [ADDR_BITS-1:0]  i_index_value,
   // Processor state and address checks for the issued operation
   input  wire logic                  i_user_mode,
   input  wire logic                  i_data_reloc,
   input  wire logic                  i_no_access_zone,
   input  wire logic                  i_tlb_hit,
   input  wire logic                  i_cachable,
   input  wire logic                  i_dac_match,
   // Main memory line fill
   input  wire logic                  i_fill_done,
   output logic                       o_fill_req,
   output logic [ADDR_BITS-1:0]       o_fill_addr,
   // Completion and exception report
   output logic                       o_busy,
   output logic                       o_done,
   output icmo_pkg::icmo_exc_type     o_exc,
   output logic [ADDR_BITS-1:0]       o_exc_addr
);
   localparam int TAG_BITS = ADDR_BITS - `ICMO_TAG_LSB;
   // Tag and class slicing assume these widths
   if (ADDR_BITS != 32 || SET_BITS != `ICMO_SET_BITS) begin : g_bad_width
      $error("icmo_ctrl: unsupported address or class width");
   end

   typedef enum logic [1:0] {ICMO_ST_IDLE, ICMO_ST_FILL, ICMO_ST_CLEAR} icmo_state_type;
   icmo_state_type state;
   icmo_state_type next_state;

   icmo_op_type op;
   logic [4:0]  base_field;
   logic [4:0]  index_field;

   icmo_decode u_decode (
      .i_instr                (i_instr),
      .o_op                   (op),
      .o_base_register_field  (base_field),
      .o_index_register_field (index_field)
   );

   icmo_tag_if #(.SET_BITS(SET_BITS), .TAG_BITS(TAG_BITS)) tag_bus ();

   icmo_tag_store #(.SET_BITS(SET_BITS), .TAG_BITS(TAG_BITS)) u_store (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .tag_bus   (tag_bus)
   );

   // base forced to zero for field 0
   wire logic [ADDR_BITS-1:0] base = (base_field == 5'h00) ? '0 : i_base_value;
   wire logic [ADDR_BITS-1:0] ea   = base + i_index_value;
   logic [ADDR_BITS-1:0] line_addr;
   wire logic [ADDR_BITS-1:0] ea_line = {ea[ADDR_BITS-1:`ICMO_OFFSET_BITS], {`ICMO_OFFSET_BITS{1'b0}}};
   wire logic [ADDR_BITS-1:0] cur_line = (state == ICMO_ST_FILL) ? line_addr : ea_line;

   // class bits above the line offset
   assign tag_bus.set = cur_line[`ICMO_SET_LSB +: SET_BITS];
   assign tag_bus.tag = cur_line[ADDR_BITS-1:`ICMO_TAG_LSB];

   wire logic idle     = (state == ICMO_ST_IDLE);
   wire logic take     = idle && i_issue;
   wire logic is_inv   = take && (op == ICMO_OP_INVALIDATE);
   wire logic is_touch = take && (op == ICMO_OP_TOUCH);
   wire logic is_all   = take && (op == ICMO_OP_INV_ALL);

   // zone fault only user and relocated
   wire logic zone_fault = i_user_mode && i_data_reloc && i_no_access_zone;
   wire logic tlb_fault  = i_data_reloc && !i_tlb_hit;
   wire logic inv_dbg    = is_inv && i_dac_match;
   wire logic touch_dbg  = is_touch && i_dac_match;
   // suppressed faults make touch a no-op
   wire logic touch_ok   = is_touch && !zone_fault && !tlb_fault;
   wire logic prog_fault = is_all && i_user_mode;

   // data-side codes, plus program code for whole invalidate in user mode
   wire icmo_exc_type next_exc =
      prog_fault                   ? ICMO_EXC_PROGRAM :
      (is_inv && tlb_fault)        ? ICMO_EXC_DATA_TLB_MISS :
      (is_inv && zone_fault)       ? ICMO_EXC_DATA_STORAGE :
      (inv_dbg || (touch_dbg && touch_ok)) ? ICMO_EXC_DEBUG : ICMO_EXC_NONE;

   wire logic inv_ok = is_inv && (next_exc == ICMO_EXC_NONE);
   wire logic start_fill = touch_ok && !touch_dbg && i_cachable && !tag_bus.hit;
   wire logic start_clear = is_all && !i_user_mode;

   // invalidate on hit; miss leaves store alone
   assign tag_bus.inv_line = inv_ok && tag_bus.hit;
   assign tag_bus.inv_all  = start_clear;
   assign tag_bus.fill     = (state == ICMO_ST_FILL) && i_fill_done;

   wire logic finish_clear = (state == ICMO_ST_CLEAR) && !tag_bus.clearing && !tag_bus.inv_all;
   wire logic next_done = (take && !start_fill && !start_clear) || tag_bus.fill || finish_clear;

   always_comb begin
      next_state = state;
      unique case (state)
         ICMO_ST_IDLE: begin
            if (start_fill) next_state = ICMO_ST_FILL;
            else if (start_clear) next_state = ICMO_ST_CLEAR;
         end
         ICMO_ST_FILL: begin
            if (i_fill_done) next_state = ICMO_ST_IDLE;
         end
         ICMO_ST_CLEAR: begin
            if (finish_clear) next_state = ICMO_ST_IDLE;
         end
      endcase
   end

   // Clear state waits one cycle for the walker to raise its busy flag
   logic clear_armed;
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         state       <= ICMO_ST_IDLE;
         line_addr   <= '0;
         clear_armed <= 1'b0;
         o_fill_req  <= 1'b0;
         o_fill_addr <= '0;
         o_busy      <= 1'b0;
         o_done      <= 1'b0;
         o_exc       <= ICMO_EXC_NONE;
         o_exc_addr  <= '0;
      end else begin
         state       <= (state == ICMO_ST_CLEAR && !clear_armed) ? ICMO_ST_CLEAR : next_state;
         clear_armed <= (state == ICMO_ST_CLEAR);
         if (start_fill) line_addr <= ea_line;
         o_fill_req  <= start_fill || ((state == ICMO_ST_FILL) && !i_fill_done);
         if (start_fill) o_fill_addr <= ea_line;
         o_busy      <= (next_state != ICMO_ST_IDLE) || (start_clear);
         o_done      <= next_done && (state != ICMO_ST_CLEAR || clear_armed);
         o_exc       <= take ? next_exc : ICMO_EXC_NONE;
         if (take) o_exc_addr <= ea;
      end
   end
endmodule
`default_nettype wire

// *** common/icmo_params.svh ***
`ifndef ICMO_PARAMS_SVH
`define ICMO_PARAMS_SVH
// Instruction field positions (bit 0 is the msb in the documented numbering)
`define ICMO_PRIMARY_OP      6'h1F
`define ICMO_XO_INVALIDATE   10'h3D6
`define ICMO_XO_TOUCH        10'h106
`define ICMO_XO_INV_ALL      10'h3C6
`define ICMO_OPCD_MSB        31
`define ICMO_OPCD_LSB        26
`define ICMO_BASE_MSB        20
`define ICMO_BASE_LSB        16
`define ICMO_INDEX_MSB       15
`define ICMO_INDEX_LSB       11
`define ICMO_XO_MSB          10
`define ICMO_XO_LSB          1
// Line of 32 bytes, class index taken from address bits 19:26 (msb-0)
`define ICMO_LINE_BYTES      32
`define ICMO_OFFSET_BITS     5
`define ICMO_SET_BITS        8
`define ICMO_SET_LSB         5
`define ICMO_TAG_LSB         13
`define ICMO_LRU_RESET       1'b0
`endif

// *** common/icmo_pkg.sv ***
package icmo_pkg;
   typedef enum logic [1:0] {
      ICMO_OP_NONE,
      ICMO_OP_INVALIDATE,
      ICMO_OP_TOUCH,
      ICMO_OP_INV_ALL
   } icmo_op_type;
   typedef enum logic [2:0] {
      ICMO_EXC_NONE,
      ICMO_EXC_DATA_STORAGE,
      ICMO_EXC_DATA_TLB_MISS,
      ICMO_EXC_PROGRAM,
      ICMO_EXC_DEBUG
   } icmo_exc_type;
endpackage

// *** common/icmo_tag_if.sv ***
`timescale 1ns/100ps
`default_nettype none
// Carries lookup, invalidate and fill requests between controller and tag store
interface icmo_tag_if #(parameter int SET_BITS = 8, parameter int TAG_BITS = 19);
   logic [SET_BITS-1:0] set;
   logic [TAG_BITS-1:0] tag;
   logic                hit;
   logic                inv_line;
   logic                inv_all;
   logic                fill;
   logic                clearing;
   modport ctrl (output set, output tag, output inv_line, output inv_all, output fill,
                 input hit, input clearing);
   modport store (input set, input tag, input inv_line, input inv_all, input fill,
                  output hit, output clearing);
endinterface
`default_nettype wire

// *** src/icmo_decode.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "icmo_params.svh"
module icmo_decode
   import icmo_pkg::*;
(
   // Instruction word
   input  wire logic [31:0] i_instr,
   // Decoded operation and register fields
   output icmo_pkg::icmo_op_type o_op,
   output logic [4:0]            o_base_register_field,
   output logic [4:0]            o_index_register_field
);
   wire logic [5:0] primary  = i_instr[`ICMO_OPCD_MSB:`ICMO_OPCD_LSB];
   wire logic [9:0] extended = i_instr[`ICMO_XO_MSB:`ICMO_XO_LSB];
   wire logic       is_x     = (primary == `ICMO_PRIMARY_OP);
   assign o_base_register_field  = i_instr[`ICMO_BASE_MSB:`ICMO_BASE_LSB];
   assign o_index_register_field = i_instr[`ICMO_INDEX_MSB:`ICMO_INDEX_LSB];
   // invalidate decode; touch decode; whole-cache decode
   assign o_op = !is_x                             ? ICMO_OP_NONE :
                 (extended == `ICMO_XO_INVALIDATE) ? ICMO_OP_INVALIDATE :
                 (extended == `ICMO_XO_TOUCH)      ? ICMO_OP_TOUCH :
                 (extended == `ICMO_XO_INV_ALL)    ? ICMO_OP_INV_ALL : ICMO_OP_NONE;
endmodule
`default_nettype wire

// *** src/icmo_tag_store.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "icmo_params.svh"
module icmo_tag_store #(
   parameter int SET_BITS = 8,
   parameter int TAG_BITS = 19
) (
   // Clock and reset
   input  wire logic  i_ref_clk,
   input  wire logic  i_rst,
   // Controller side
   icmo_tag_if.store  tag_bus
);
   localparam int SETS = 1 << SET_BITS;
   logic [TAG_BITS-1:0] tag_a [SETS];
   logic [TAG_BITS-1:0] tag_b [SETS];
   logic [SETS-1:0]     valid_a;
   logic [SETS-1:0]     valid_b;
   logic [SETS-1:0]     lru;
   logic                clearing;
   logic [SET_BITS-1:0] clear_idx;
   wire logic hit_a = valid_a[tag_bus.set] && (tag_a[tag_bus.set] == tag_bus.tag);
   wire logic hit_b = valid_b[tag_bus.set] && (tag_b[tag_bus.set] == tag_bus.tag);
   wire logic way_b = lru[tag_bus.set];
   assign tag_bus.hit      = hit_a || hit_b;
   assign tag_bus.clearing = clearing;
   always_ff @(posedge i_ref_clk) begin
      if (tag_bus.fill && !way_b) tag_a[tag_bus.set] <= tag_bus.tag;
      if (tag_bus.fill &&  way_b) tag_b[tag_bus.set] <= tag_bus.tag;
   end
   // Valid bits walk one class per cycle so the store stays a plain array
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         valid_a   <= '0;
         valid_b   <= '0;
         lru       <= '0;
         clearing  <= 1'b0;
         clear_idx <= '0;
      end else if (clearing) begin
         valid_a[clear_idx] <= 1'b0;
         valid_b[clear_idx] <= 1'b0;
         lru[clear_idx]     <= `ICMO_LRU_RESET;
         clear_idx          <= clear_idx + 1'b1;
         clearing           <= (clear_idx != SET_BITS'(SETS - 1));
      end else if (tag_bus.inv_all) begin
         clearing  <= 1'b1;
         clear_idx <= '0;
      end else if (tag_bus.inv_line) begin
         if (hit_a) valid_a[tag_bus.set] <= 1'b0;
         if (hit_b) valid_b[tag_bus.set] <= 1'b0;
      end else if (tag_bus.fill) begin
         if (way_b) valid_b[tag_bus.set] <= 1'b1;
         else       valid_a[tag_bus.set] <= 1'b1;
         lru[tag_bus.set] <= ~way_b;
      end
   end
endmodule
`default_nettype wire

// *** sim/icmo_ctrl_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
module icmo_ctrl_asserts
   import icmo_pkg::*;
#(
   parameter int ADDR_BITS = 32,
   parameter int SET_BITS  = 8
) (
   // Clock and reset
   input  wire logic                   i_ref_clk,
   input  wire logic                   i_rst,
   // Issue side
   input  wire logic                   i_issue,
   input  wire logic [31:0]            i_instr,
   input  wire logic [ADDR_BITS-1:0]   i_base_value,
   input  wire logic [ADDR_BITS-1:0]   i_index_value,
   input  wire logic                   i_user_mode,
   input  wire logic                   i_data_reloc,
   input  wire logic                   i_no_access_zone,
   input  wire logic                   i_tlb_hit,
   input  wire logic                   i_cachable,
   // Fill and report
   input  wire logic                   i_fill_done,
   input  wire logic                   o_fill_req,
   input  wire logic [ADDR_BITS-1:0]   o_fill_addr,
   input  wire logic                   o_busy,
   input  wire logic                   o_done,
   input  wire icmo_pkg::icmo_exc_type o_exc,
   input  wire logic [ADDR_BITS-1:0]   o_exc_addr
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   // Reserved bits must be clear, their outcome is undefined
   wire logic                 cache_op = i_issue && !o_busy && i_instr[31:26] == 6'h1F && i_instr[25:21] == 5'h00
                                         && !i_instr[0];
   wire logic                 inv      = cache_op && i_instr[10:1] == 10'h3D6;
   wire logic                 touch    = cache_op && i_instr[10:1] == 10'h106;
   wire logic                 inv_all  = cache_op && i_instr[10:1] == 10'h3C6;
   wire logic [ADDR_BITS-1:0] ea       = (i_instr[20:16] == 5'h00 ? '0 : i_base_value) + i_index_value;
   AST_PROG_USER: assert property (inv_all && i_user_mode |=> o_done && o_exc == ICMO_EXC_PROGRAM)
      else $error("user whole invalidate not refused");
   AST_INVALL_QUIET: assert property (inv_all && !i_user_mode |=> o_busy && o_exc == ICMO_EXC_NONE)
      else $error("whole invalidate raised a fault");
   AST_INVALL_WALK: assert property (inv_all && !i_user_mode |=> o_busy ##[200:300] o_done)
      else $error("whole invalidate walk length wrong");
   AST_INV_STORAGE: assert property (inv && i_user_mode && i_data_reloc && i_no_access_zone && i_tlb_hit
                                     |=> o_exc == ICMO_EXC_DATA_STORAGE)
      else $error("invalidate storage fault missing");
   AST_INV_TLB: assert property (inv && i_data_reloc && !i_tlb_hit |=> o_exc == ICMO_EXC_DATA_TLB_MISS)
      else $error("invalidate translation fault missing");
   AST_TOUCH_QUIET: assert property (touch |=> o_exc inside {ICMO_EXC_NONE, ICMO_EXC_DEBUG})
      else $error("touch raised a fault");
   AST_EA: assert property (inv || touch |=> o_exc_addr == $past(ea))
      else $error("effective address wrong");
   AST_INV_NOFILL: assert property (inv |=> o_done && !o_fill_req)
      else $error("invalidate did not finish at once");
   AST_NC_NOFILL: assert property (touch && !i_cachable |=> o_done && !o_fill_req)
      else $error("uncached touch filled");
   AST_FILL_HOLD: assert property (o_fill_req && !i_fill_done |=> o_fill_req && $stable(o_fill_addr)
                                   && o_fill_addr[4:0] == 5'h00)
      else $error("fill request unstable");
   AST_FILL_END: assert property (o_fill_req && i_fill_done |=> !o_fill_req && o_done)
      else $error("fill did not end");
endmodule
bind icmo_ctrl icmo_ctrl_asserts #(.ADDR_BITS(ADDR_BITS), .SET_BITS(SET_BITS)) chk_u (
   .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_issue(i_issue), .i_instr(i_instr), .i_base_value(i_base_value),
   .i_index_value(i_index_value), .i_user_mode(i_user_mode), .i_data_reloc(i_data_reloc),
   .i_no_access_zone(i_no_access_zone), .i_tlb_hit(i_tlb_hit), .i_cachable(i_cachable),
   .i_fill_done(i_fill_done), .o_fill_req(o_fill_req), .o_fill_addr(o_fill_addr), .o_busy(o_busy),
   .o_done(o_done), .o_exc(o_exc), .o_exc_addr(o_exc_addr));
`default_nettype wire

// *** sim/icmo_mem_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module icmo_mem_model (
   // Clock and reset
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst,
   // Line fill handshake
   input  wire logic        i_fill_req,
   input  wire logic [31:0] i_fill_addr,
   input  wire logic        i_slow,
   output logic             o_fill_done,
   output int               o_fills,
   output logic [31:0]      o_last_addr
);
   int wait_cnt;
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         wait_cnt    <= 0;
         o_fill_done <= 1'b0;
         o_fills     <= 0;
         o_last_addr <= 32'h0;
      end else begin
         o_fill_done <= 1'b0;
         // One pulse per request; the counter restarts while the request drops
         if (!i_fill_req || o_fill_done) begin
            wait_cnt <= 0;
         end else if (wait_cnt == (i_slow ? 9 : 1)) begin
            o_fill_done <= 1'b1;
            o_fills     <= o_fills + 1;
            o_last_addr <= i_fill_addr;
            wait_cnt    <= 0;
         end else begin
            wait_cnt <= wait_cnt + 1;
         end
      end
   end
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import icmo_pkg::*;
   logic         i_ref_clk = 1'b0;
   logic         i_rst     = 1'b1;
   logic         i_issue   = 1'b0;
   logic         slow      = 1'b0;
   logic [31:0]  i_instr   = 32'h0;
   logic [31:0]  base      = 32'h0;
   logic [31:0]  idx       = 32'h0;
   logic [5:0]   flags     = 6'h0;
   logic         fill_done;
   logic         fill_req;
   logic         busy;
   logic         done;
   logic [31:0]  fill_addr;
   logic [31:0]  exc_addr;
   logic [31:0]  last_addr;
   icmo_exc_type exc;
   int           fills;
   int           err_total = 0;
   int           checked   = 0;
   icmo_ctrl dut_u (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_issue(i_issue), .i_instr(i_instr),
      .i_base_value(base), .i_index_value(idx), .i_user_mode(flags[5]), .i_data_reloc(flags[4]),
      .i_no_access_zone(flags[3]), .i_tlb_hit(flags[2]), .i_cachable(flags[1]), .i_dac_match(flags[0]),
      .i_fill_done(fill_done), .o_fill_req(fill_req), .o_fill_addr(fill_addr), .o_busy(busy),
      .o_done(done), .o_exc(exc), .o_exc_addr(exc_addr));
   icmo_mem_model mem_u (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_fill_req(fill_req), .i_fill_addr(fill_addr),
      .i_slow(slow), .o_fill_done(fill_done), .o_fills(fills), .o_last_addr(last_addr));
   initial begin
      forever #20 i_ref_clk = ~i_ref_clk;
   end
   task automatic complete_run();
      if (err_total == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] want, input string msg);
      checked++;
      if (seen !== want) begin
         err_total++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask
   function automatic logic [31:0] mk(input logic [9:0] xo);
      mk = {6'h1F, 5'h00, 5'h03, 5'h04, xo, 1'b0};
   endfunction
   // Flags: user, reloc, no-access, tlb hit, cachable, address compare
   task automatic op(input logic [31:0] ins, input logic [31:0] b, input logic [31:0] x, input logic [5:0] f,
                     input icmo_exc_type want, input logic [31:0] ea, input int nfill);
      int n0;
      int k;
      n0 = fills;
      @(posedge i_ref_clk);
      i_issue <= 1'b1;
      i_instr <= ins;
      base    <= b;
      idx     <= x;
      flags   <= f;
      @(posedge i_ref_clk);
      i_issue <= 1'b0;
      #1;
      check(exc, want, "exception code");
      if (ins[10:1] != 10'h3C6) check(exc_addr, ea, "effective address");
      for (k = 0; k < 400 && done !== 1'b1; k++) begin
         @(posedge i_ref_clk);
         #1;
      end
      if (k < 400) begin
         check(fills - n0, nfill, "fill count");
      end else begin
         check(0, 1, "completion timeout");
         complete_run();
      end
   endtask
   task automatic touch_scn();
      op(mk(10'h106), 32'h00012340, 32'h47, 6'h06, ICMO_EXC_NONE, 32'h00012387, 1);
      check(last_addr, 32'h00012380, "fill line address");
      op(mk(10'h106), 32'h00012340, 32'h47, 6'h06, ICMO_EXC_NONE, 32'h00012387, 0);
      op(mk(10'h106) & 32'hFFE0FFFF, 32'h00012340, 32'h5000, 6'h04, ICMO_EXC_NONE, 32'h5000, 0);
      op(mk(10'h106), 32'h00040000, 32'h0, 6'h3E, ICMO_EXC_NONE, 32'h00040000, 0);
      op(mk(10'h106), 32'h00040000, 32'h0, 6'h12, ICMO_EXC_NONE, 32'h00040000, 0);
      op(mk(10'h106), 32'h00012340, 32'h47, 6'h07, ICMO_EXC_DEBUG, 32'h00012387, 0);
   endtask
   task automatic inv_scn();
      op(mk(10'h3D6), 32'h00012340, 32'h47, 6'h3E, ICMO_EXC_DATA_STORAGE, 32'h00012387, 0);
      op(mk(10'h3D6), 32'h00012340, 32'h47, 6'h12, ICMO_EXC_DATA_TLB_MISS, 32'h00012387, 0);
      op(mk(10'h3D6), 32'h00012340, 32'h47, 6'h07, ICMO_EXC_DEBUG, 32'h00012387, 0);
      op(mk(10'h3D6), 32'h00012340, 32'h47, 6'h04, ICMO_EXC_NONE, 32'h00012387, 0);
      slow <= 1'b1;
      op(mk(10'h106), 32'h00012340, 32'h47, 6'h06, ICMO_EXC_NONE, 32'h00012387, 1);
      // Same class, other tag: a miss must leave the cached line alone
      op(mk(10'h3D6), 32'h00014380, 32'h0, 6'h06, ICMO_EXC_NONE, 32'h00014380, 0);
      op(mk(10'h106), 32'h00012340, 32'h47, 6'h06, ICMO_EXC_NONE, 32'h00012387, 0);
   endtask
   task automatic inv_all_scn();
      op(mk(10'h3C6), 32'h0, 32'h0, 6'h26, ICMO_EXC_PROGRAM, 32'h0, 0);
      op(mk(10'h106), 32'h00012340, 32'h47, 6'h06, ICMO_EXC_NONE, 32'h00012387, 0);
      op(mk(10'h3C6), 32'h0, 32'h0, 6'h13, ICMO_EXC_NONE, 32'h0, 0);
      op(mk(10'h106), 32'h00012340, 32'h47, 6'h06, ICMO_EXC_NONE, 32'h00012387, 1);
      op(mk(10'h3C6) | 32'h1, 32'h0, 32'h0, 6'h06, ICMO_EXC_NONE, 32'h0, 0);
   endtask
   // Reset in mid-run must drop every cached line
   task automatic reset_scn();
      op(mk(10'h106), 32'h00012340, 32'h47, 6'h06, ICMO_EXC_NONE, 32'h00012387, 1);
      @(posedge i_ref_clk);
      i_rst <= 1'b1;
      repeat (3) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      op(mk(10'h106), 32'h00012340, 32'h47, 6'h06, ICMO_EXC_NONE, 32'h00012387, 1);
   endtask
   initial begin
      repeat (8) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      op(mk(10'h3C6), 32'h0, 32'h0, 6'h00, ICMO_EXC_NONE, 32'h0, 0);
      touch_scn();
      inv_scn();
      inv_all_scn();
      reset_scn();
      complete_run();
   end
endmodule
`default_nettype wire
